// ### verilog/fault_supervisor_regs.vh
// Constants for the half-bridge fault supervisor.
// Assumes inclusion by bare name from the design file.
`ifndef FAULT_SUPERVISOR_REGS_VH
`define FAULT_SUPERVISOR_REGS_VH

// ****************************************
// Global status bit positions
// ****************************************
`define GSTAT_TPW_BIT 1
`define GSTAT_OT_BIT 2
`define GSTAT_PG_BIT 3
`define GSTAT_OV_BIT 4
`define GSTAT_UV_BIT 5
`define GSTAT_LE_BIT 6

// ****************************************
// Reset values, channel count and timing
// ****************************************
`define FLAG_RESET 1'b0
`define PG_RESET 1'b0
`define CHANNELS 12
`define OPENLOAD_FILTER_NS 2000
`define CLK_PERIOD_NS 10
`define OPENLOAD_FILTER_CYCLES ((`OPENLOAD_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### verilog/half_bridge_fault_supervisor.v
// Fault supervision for a twelve-channel half-bridge driver.
// Assumes analog comparators and current sensors arrive synchronous to core_clk,
// and that the serial framing decodes clear requests into per-flag strobes.
//
// Notes on behaviour
// - Warning temperature sets pre-warning flag
// - Pre-warning flag cleared only by host
// - Pre-warning never disables any output
// - Shutdown temperature latches outputs off, sets flag
// - Outputs stay off until overheat flag cleared
// - Cooled overheat flag reads set until the host clears it
// - Supply undervoltage: outputs off, flag latched
// - Undervoltage does not reset logic state
// - Undervoltage recovery reactivates outputs automatically
// - Supply overvoltage: outputs off, flag latched
// - Overvoltage recovery reactivates outputs automatically
// - Extended select picks second overvoltage pair
// - Logic undervoltage enters reset, serial stops
// - Logic reset initializes state, outputs high-Z
// - Reset released only above power-on level
// - Power-good bit reads 0 after reset
// - Filtered low current latches open-load flag
// - Any open-load flag sets load fault summary
// - Open-load never changes output state
// - Disable bit masks freewheeling open-load detection
// - Operation bit 1 reads then clears flags
`include "fault_supervisor_regs.vh"

module half_bridge_fault_supervisor #(
  parameter N = `CHANNELS,
  parameter OL_CYCLES = `OPENLOAD_FILTER_CYCLES
) (
  input wire core_clk,
  input wire rst,
  input wire logic_supply_ok,
  input wire enable_pin,
  input wire temp_warn,
  input wire temp_shutdown,
  input wire supply_below_uv_off,
  input wire supply_above_uv_on,
  input wire supply_above_ov1_off,
  input wire supply_below_ov1_on,
  input wire supply_above_ov2_off,
  input wire supply_below_ov2_on,
  input wire extended_overvoltage_select,
  input wire negative_current_openload_disable,
  input wire [N-1:0] high_side_switch_enable,
  input wire [N-1:0] low_side_switch_enable,
  input wire [N-1:0] high_side_low_current,
  input wire [N-1:0] low_side_low_current,
  input wire [N-1:0] high_side_freewheel,
  input wire [N-1:0] low_side_freewheel,
  input wire status_access,
  input wire operation_select_bit,
  input wire [7:0] global_clear_mask,
  input wire [N-1:0] high_side_ol_clear_mask,
  input wire [N-1:0] low_side_ol_clear_mask,
  output reg thermal_prewarn_flag,
  output reg overheat_shutdown_flag,
  output reg supply_undervoltage_flag,
  output reg supply_overvoltage_flag,
  output reg power_good_indicator,
  output reg load_fault_summary,
  output reg [N-1:0] high_side_openload_flag,
  output reg [N-1:0] low_side_openload_flag,
  output reg [N-1:0] high_side_drive,
  output reg [N-1:0] low_side_drive,
  output reg serial_ready,
  output reg [7:0] global_status_reg
);

  // ****************************************
  // Reset and supply state
  // ****************************************
  wire int_rst;
  wire clr_act;
  wire ov_off;
  wire ov_on;
  wire next_uv_lock;
  wire next_ov_lock;
  wire [N-1:0] clr_hs;
  wire [N-1:0] clr_ls;
  wire [N-1:0] hs_low;
  wire [N-1:0] ls_low;
  wire [N-1:0] hs_hit;
  wire [N-1:0] ls_hit;
  wire [N-1:0] next_hs_ol;
  wire [N-1:0] next_ls_ol;
  wire next_le;
  wire next_pg;
  wire stage_off;
  reg next_tpw;
  reg next_ot;
  reg next_uv;
  reg next_ov;
  reg uv_lock;
  reg ov_lock;
  reg [N-1:0] next_hs_drive;
  reg [N-1:0] next_ls_drive;
  reg [7:0] next_status;

  // Logic-supply loss acts as a reset; release waits for the good level
  assign int_rst = rst | ~logic_supply_ok;
  assign clr_act = status_access & operation_select_bit;

  // Threshold pair chosen by the extended select bit
  assign ov_off = extended_overvoltage_select ? supply_above_ov2_off
                                              : supply_above_ov1_off;
  assign ov_on = extended_overvoltage_select ? supply_below_ov2_on
                                             : supply_below_ov1_on;

  // Lockouts hold until the switch-on level, then release on their own
  assign next_uv_lock = supply_below_uv_off | (uv_lock & ~supply_above_uv_on);
  assign next_ov_lock = ov_off | (ov_lock & ~ov_on);

  // ****************************************
  // Flag set and clear, set wins
  // ****************************************
  always @* begin
    next_tpw = thermal_prewarn_flag;
    if (clr_act && global_clear_mask[`GSTAT_TPW_BIT])
      next_tpw = 1'b0;
    if (temp_warn)
      next_tpw = 1'b1;
    next_ot = overheat_shutdown_flag;
    if (clr_act && global_clear_mask[`GSTAT_OT_BIT])
      next_ot = 1'b0;
    if (temp_shutdown)
      next_ot = 1'b1;
    next_uv = supply_undervoltage_flag;
    if (clr_act && global_clear_mask[`GSTAT_UV_BIT])
      next_uv = 1'b0;
    if (supply_below_uv_off)
      next_uv = 1'b1;
    next_ov = supply_overvoltage_flag;
    if (clr_act && global_clear_mask[`GSTAT_OV_BIT])
      next_ov = 1'b0;
    if (ov_off)
      next_ov = 1'b1;
  end

  // ****************************************
  // Open-load filter, one counter per switch
  // ****************************************
  assign clr_hs = {N{clr_act}} & high_side_ol_clear_mask;
  assign clr_ls = {N{clr_act}} & low_side_ol_clear_mask;
  assign hs_low = high_side_drive & high_side_low_current &
    ~({N{negative_current_openload_disable}} & high_side_freewheel);
  assign ls_low = low_side_drive & low_side_low_current &
    ~({N{negative_current_openload_disable}} & low_side_freewheel);

  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_ol
      openload_filter #(
        .CNT_W(16),
        .OL_CYCLES(OL_CYCLES)
      ) i_hs_filter (
        .core_clk(core_clk),
        .rst(int_rst),
        .low_current(hs_low[g]),
        .hit(hs_hit[g])
      );
      openload_filter #(
        .CNT_W(16),
        .OL_CYCLES(OL_CYCLES)
      ) i_ls_filter (
        .core_clk(core_clk),
        .rst(int_rst),
        .low_current(ls_low[g]),
        .hit(ls_hit[g])
      );
    end
  endgenerate

  assign next_hs_ol = hs_hit | (high_side_openload_flag & ~clr_hs);
  assign next_ls_ol = ls_hit | (low_side_openload_flag & ~clr_ls);
  assign next_le = |{next_hs_ol, next_ls_ol};

  // ****************************************
  // Supply lockouts
  // ****************************************
  always @(posedge core_clk) begin
    if (int_rst) begin
      uv_lock <= 1'b0;
      ov_lock <= 1'b0;
    end else begin
      // Undervoltage only gates the stages; nothing here is reset by it
      uv_lock <= next_uv_lock;
      ov_lock <= next_ov_lock;
    end
  end

  // ****************************************
  // Thermal flags
  // ****************************************
  always @(posedge core_clk) begin
    if (int_rst) begin
      // Digital state initialised on any reset
      thermal_prewarn_flag <= `FLAG_RESET;
      overheat_shutdown_flag <= `FLAG_RESET;
    end else begin
      thermal_prewarn_flag <= next_tpw;
      overheat_shutdown_flag <= next_ot;
    end
  end

  // ****************************************
  // Supply flags
  // ****************************************
  always @(posedge core_clk) begin
    if (int_rst) begin
      supply_undervoltage_flag <= `FLAG_RESET;
      supply_overvoltage_flag <= `FLAG_RESET;
    end else begin
      supply_undervoltage_flag <= next_uv;
      supply_overvoltage_flag <= next_ov;
    end
  end

  // ****************************************
  // Open-load flags and summary
  // ****************************************
  always @(posedge core_clk) begin
    if (int_rst) begin
      high_side_openload_flag <= {N{1'b0}};
      low_side_openload_flag <= {N{1'b0}};
      load_fault_summary <= `FLAG_RESET;
    end else begin
      high_side_openload_flag <= next_hs_ol;
      low_side_openload_flag <= next_ls_ol;
      load_fault_summary <= next_le;
    end
  end

  // ****************************************
  // Power-good and serial readiness
  // ****************************************
  // Power-good stays 0 until the host clears it once enabled
  assign next_pg = power_good_indicator |
    (enable_pin & clr_act & global_clear_mask[`GSTAT_PG_BIT]);

  always @(posedge core_clk) begin
    if (int_rst) begin
      power_good_indicator <= `PG_RESET;
      serial_ready <= 1'b0;
    end else begin
      power_good_indicator <= next_pg;
      serial_ready <= 1'b1;
    end
  end

  // ****************************************
  // Output stages
  // ****************************************
  // Any shutdown source forces the stages off; enables are left as they are
  assign stage_off = next_ot | next_uv_lock | next_ov_lock;

  always @* begin
    next_hs_drive = high_side_switch_enable;
    // Cross-current guard: low side yields when both enables are set
    next_ls_drive = low_side_switch_enable & ~high_side_switch_enable;
    if (stage_off) begin
      next_hs_drive = {N{1'b0}};
      next_ls_drive = {N{1'b0}};
    end
  end

  always @(posedge core_clk) begin
    if (int_rst) begin
      // Stages off while the logic is held in reset
      high_side_drive <= {N{1'b0}};
      low_side_drive <= {N{1'b0}};
    end else begin
      high_side_drive <= next_hs_drive;
      low_side_drive <= next_ls_drive;
    end
  end

  // ****************************************
  // Global status byte
  // ****************************************
  always @* begin
    next_status = 8'h00;
    next_status[`GSTAT_TPW_BIT] = next_tpw;
    next_status[`GSTAT_OT_BIT] = next_ot;
    next_status[`GSTAT_PG_BIT] = next_pg;
    next_status[`GSTAT_OV_BIT] = next_ov;
    next_status[`GSTAT_UV_BIT] = next_uv;
    next_status[`GSTAT_LE_BIT] = next_le;
  end

  always @(posedge core_clk) begin
    if (int_rst)
      global_status_reg <= 8'h00;
    else
      global_status_reg <= next_status;
  end

endmodule // half_bridge_fault_supervisor

// ****************************************
// Open-load filter for one switch
// ****************************************
// Raises hit once low current has been seen for OL_CYCLES-1 edges in a row
module openload_filter #(
  parameter CNT_W = 16,
  parameter OL_CYCLES = `OPENLOAD_FILTER_CYCLES
) (
  input wire core_clk,
  input wire rst,
  input wire low_current,
  output wire hit
);

  localparam integer LIMIT = OL_CYCLES - 1;

  reg [CNT_W-1:0] count;
  reg [CNT_W-1:0] next_count;
  wire [31:0] count_wide;
  wire at_limit;

  // Counter parks at the limit so a long open load never wraps it
  assign count_wide = {{(32-CNT_W){1'b0}}, count};
  assign at_limit = (count_wide >= LIMIT);
  assign hit = low_current & at_limit;

  always @* begin
    next_count = count;
    if (!low_current)
      next_count = {CNT_W{1'b0}};
    else if (!at_limit)
      next_count = count + {{(CNT_W-1){1'b0}}, 1'b1};
  end

  always @(posedge core_clk) begin
    if (rst)
      count <= {CNT_W{1'b0}};
    else
      count <= next_count;
  end

endmodule // openload_filter

// ### dv/half_bridge_fault_supervisor_properties.sv
// Concurrent checks on the fault supervisor outputs.
// Assumes binding to the supervisor top; comparators arrive synchronous to core_clk.
module fault_supervisor_checker #(parameter N = 12) (
  input wire core_clk, rst, logic_supply_ok, temp_warn, temp_shutdown, supply_below_uv_off,
  input wire status_access, operation_select_bit, thermal_prewarn_flag, overheat_shutdown_flag,
  input wire supply_undervoltage_flag, load_fault_summary, serial_ready, power_good_indicator,
  input wire [7:0] global_clear_mask,
  input wire [N-1:0] high_side_openload_flag,
  input wire [N-1:0] high_side_drive
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst || !logic_supply_ok);
  wire clr_tpw = status_access && operation_select_bit && global_clear_mask[1];
  property p_warn_set; temp_warn |=> thermal_prewarn_flag; endproperty
  a_warn_set: assert property (p_warn_set) else $error("prewarn not set");
  property p_warn_hold; thermal_prewarn_flag && !clr_tpw |=> thermal_prewarn_flag; endproperty
  a_warn_hold: assert property (p_warn_hold) else $error("prewarn lost");
  property p_ot_set; temp_shutdown |=> overheat_shutdown_flag && high_side_drive == '0; endproperty
  a_ot_set: assert property (p_ot_set) else $error("overheat not latched");
  property p_ot_off; overheat_shutdown_flag |-> high_side_drive == '0; endproperty
  a_ot_off: assert property (p_ot_off) else $error("drive during overheat");
  property p_uv; supply_below_uv_off |=> supply_undervoltage_flag && high_side_drive == '0;
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage not handled");
  property p_le; |high_side_openload_flag |-> load_fault_summary; endproperty
  a_le: assert property (p_le) else $error("summary missing");
  property p_clear; clr_tpw && !temp_warn |=> !thermal_prewarn_flag; endproperty
  a_clear: assert property (p_clear) else $error("clear ignored");
  property p_pg; $rose(serial_ready) |-> !power_good_indicator; endproperty
  a_pg: assert property (p_pg) else $error("power good high after reset");
  property p_lrst;
    disable iff (rst) !logic_supply_ok |=> !serial_ready && high_side_drive == '0;
  endproperty
  a_lrst: assert property (p_lrst) else $error("logic reset ignored");
  c_ot: cover property (temp_shutdown);
  c_uv: cover property (supply_below_uv_off);
  c_ol: cover property ($rose(load_fault_summary));
endmodule // fault_supervisor_checker
bind half_bridge_fault_supervisor fault_supervisor_checker #(.N(N)) i_chk (.core_clk, .rst,
  .logic_supply_ok, .temp_warn, .temp_shutdown, .supply_below_uv_off, .status_access,
  .operation_select_bit, .thermal_prewarn_flag, .overheat_shutdown_flag,
  .supply_undervoltage_flag, .load_fault_summary, .serial_ready, .power_good_indicator,
  .global_clear_mask, .high_side_openload_flag, .high_side_drive);

// ### dv/host_model.sv
// Host side of the status interface: one-cycle read or read-and-clear strobes.
// Assumes the bench calls access() and core_clk runs free.
module host_model #(parameter N = 12) (
  input wire core_clk,
  output logic status_access, operation_select_bit,
  output logic [7:0] global_clear_mask,
  output logic [N-1:0] high_side_ol_clear_mask, low_side_ol_clear_mask
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {status_access, operation_select_bit, global_clear_mask} = '0;
  initial {high_side_ol_clear_mask, low_side_ol_clear_mask} = '0;
  // Idle masks are inverted so a stale value never looks like a request
  task access(input logic op, input logic [7:0] g, input logic [N-1:0] hm, lm);
    @(negedge core_clk);
    {status_access, operation_select_bit, global_clear_mask} = {1'b1, op, g};
    {high_side_ol_clear_mask, low_side_ol_clear_mask} = {hm, lm};
    @(negedge core_clk);
    {status_access, operation_select_bit, global_clear_mask} = {1'b0, ~op, ~g};
    {high_side_ol_clear_mask, low_side_ol_clear_mask} = {~hm, ~lm};
  endtask
endmodule // host_model

// ### dv/half_bridge_fault_supervisor_test.sv
// Directed bench for the fault supervisor with a short open-load filter.
// Assumes host_model drives the status strobes; inputs change at falling edges.
module half_bridge_fault_supervisor_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, rst = 1, logic_supply_ok = 1, enable_pin = 1, temp_warn = 0;
  logic temp_shutdown = 0, supply_below_uv_off = 0, supply_above_uv_on = 1;
  logic supply_above_ov1_off = 0, supply_below_ov1_on = 1, supply_above_ov2_off = 0;
  logic supply_below_ov2_on = 1, extended_overvoltage_select = 0;
  logic negative_current_openload_disable = 0;
  logic [11:0] high_side_switch_enable = 12'h00f, low_side_switch_enable = 12'h030;
  logic [11:0] high_side_low_current = '0, low_side_low_current = '0;
  logic [11:0] high_side_freewheel = '0, low_side_freewheel = '0;
  logic status_access, operation_select_bit, thermal_prewarn_flag, overheat_shutdown_flag;
  logic supply_undervoltage_flag, supply_overvoltage_flag, power_good_indicator;
  logic load_fault_summary, serial_ready;
  logic [7:0] global_clear_mask, global_status_reg;
  logic [11:0] high_side_ol_clear_mask, low_side_ol_clear_mask, high_side_openload_flag;
  logic [11:0] low_side_openload_flag, high_side_drive, low_side_drive;
  int n_fail = 0, checks = 0, cycles = 0;
  half_bridge_fault_supervisor #(.OL_CYCLES(3)) i_dut (.core_clk, .rst, .logic_supply_ok,
    .enable_pin, .temp_warn, .temp_shutdown, .supply_below_uv_off, .supply_above_uv_on,
    .supply_above_ov1_off, .supply_below_ov1_on, .supply_above_ov2_off, .supply_below_ov2_on,
    .extended_overvoltage_select, .negative_current_openload_disable, .high_side_switch_enable,
    .low_side_switch_enable, .high_side_low_current, .low_side_low_current, .high_side_freewheel,
    .low_side_freewheel, .status_access, .operation_select_bit, .global_clear_mask,
    .high_side_ol_clear_mask, .low_side_ol_clear_mask, .thermal_prewarn_flag,
    .overheat_shutdown_flag, .supply_undervoltage_flag, .supply_overvoltage_flag,
    .power_good_indicator, .load_fault_summary, .high_side_openload_flag,
    .low_side_openload_flag, .high_side_drive, .low_side_drive, .serial_ready, .global_status_reg);
  host_model i_host (.core_clk, .status_access, .operation_select_bit, .global_clear_mask,
    .high_side_ol_clear_mask, .low_side_ol_clear_mask);
  // ****************************************
  // Clock, timeout and helpers
  // ****************************************
  initial forever #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 1000) begin
      n_fail++;
      stop_test;
    end
  end
  task cyc(input int n); repeat (n) @(negedge core_clk); endtask
  task chk(input logic [11:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task stop_test;
    if (n_fail == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    cyc(6);
    rst = 0;
    cyc(1);
    chk(power_good_indicator, 0);
    chk(global_status_reg, 0);
    chk({high_side_drive, low_side_drive} == 24'h00f030, 1);
    enable_pin = 0;
    i_host.access(1, 8'h08, 0, 0);
    chk(power_good_indicator, 0);
    enable_pin = 1;
    i_host.access(1, 8'h08, 0, 0);
    chk(power_good_indicator, 1);
    temp_warn = 1;
    cyc(1);
    temp_warn = 0;
    chk(thermal_prewarn_flag, 1);
    chk(high_side_drive, 12'h00f);
    i_host.access(0, 8'h02, 0, 0);
    chk(thermal_prewarn_flag, 1);
    i_host.access(1, 8'h02, 0, 0);
    chk(thermal_prewarn_flag, 0);
    temp_shutdown = 1;
    cyc(1);
    temp_shutdown = 0;
    cyc(3);
    chk(low_side_drive, 0);
    chk(overheat_shutdown_flag, 1);
    i_host.access(1, 8'h04, 0, 0);
    chk(overheat_shutdown_flag, 0);
    chk(high_side_drive, 12'h00f);
    supply_above_uv_on = 0;
    supply_below_uv_off = 1;
    cyc(1);
    chk(high_side_drive, 0);
    supply_below_uv_off = 0;
    supply_above_uv_on = 1;
    cyc(2);
    chk(high_side_drive, 12'h00f);
    chk(supply_undervoltage_flag, 1);
    chk(power_good_indicator, 1);
    for (int i = 0; i < 2; i++) begin
      extended_overvoltage_select = i[0];
      {supply_above_ov2_off, supply_above_ov1_off} = 2'b01 << i;
      {supply_below_ov2_on, supply_below_ov1_on} = ~(2'b01 << i);
      cyc(2);
      chk(high_side_drive, 0);
      chk(supply_overvoltage_flag, 1);
      {supply_above_ov2_off, supply_above_ov1_off} = 2'b00;
      {supply_below_ov2_on, supply_below_ov1_on} = 2'b11;
      cyc(2);
      chk(high_side_drive, 12'h00f);
      i_host.access(1, 8'h10, 0, 0);
      chk(supply_overvoltage_flag, 0);
    end
    {supply_above_ov1_off, supply_below_ov1_on} = 2'b10;
    cyc(2);
    chk(high_side_drive, 12'h00f);
    {supply_above_ov1_off, supply_below_ov1_on} = 2'b01;
    high_side_low_current = 12'h001;
    cyc(2);
    chk(high_side_openload_flag, 0);
    cyc(3);
    chk(high_side_openload_flag, 12'h001);
    chk(load_fault_summary, 1);
    chk(global_status_reg, 12'h068);
    chk(high_side_drive, 12'h00f);
    high_side_low_current = 0;
    i_host.access(1, 0, 12'h001, 0);
    chk(high_side_openload_flag, 0);
    negative_current_openload_disable = 1;
    low_side_freewheel = 12'h010;
    low_side_low_current = 12'h010;
    cyc(6);
    chk(low_side_openload_flag, 0);
    negative_current_openload_disable = 0;
    cyc(6);
    chk(low_side_openload_flag, 12'h010);
    logic_supply_ok = 0;
    cyc(1);
    chk(serial_ready, 0);
    chk(low_side_openload_flag | low_side_drive, 0);
    logic_supply_ok = 1;
    cyc(1);
    chk(serial_ready, 1);
    chk(power_good_indicator, 0);
    stop_test;
  end
endmodule // half_bridge_fault_supervisor_test
